/* src/crystal_pll_clock_control.sv */
// apb register block, flag synchronisers and glitch-free clock path for crystal and pll
`timescale 1ns/10ps

module crystal_pll_clock_control
    import clock_ctrl_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire apbReq_type  apbReq,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ringOscClk,
    input  wire logic        crystalClk,
    input  wire logic        pllClk,
    input  wire logic        crystalReadyRaw,
    input  wire logic        pllLockRaw,
    output logic             crystalEnable,
    output logic             pllPowerDown,
    output pllCfg_type       pllCfg,
    output logic             hfClk
);
    logic              xtalEn_q;
    pllCfg_type        cfg_q;
    logic [5:0]        fdiv_q;
    logic [5:0]        fone_q;
    logic [31:0]       prdata_q;
    logic              pslverr_q;
    logic [SYNC_N-1:0] syncA_q;
    logic [SYNC_N-1:0] syncB_q;
    logic              setupPhase;
    logic              accessPhase;
    logic              wrAccess;
    logic              addrHit;
    logic              readyFlag;
    logic              lockFlag;
    logic              pllRef;
    logic              pllPath;
    logic              pathPrev_q;
    logic              pathRise;
    logic [5:0]        cnt_q;
    logic              divOut_q;
    logic [5:0]        activeN_q;
    logic              activeOne_q;
    logic              finalClk;
    logic              selActive_q;
    logic              hfClk_q;

    // apb phase decode; zero wait states, answer in the first access cycle
    assign setupPhase  = apbReq.psel && !apbReq.penable;
    assign accessPhase = apbReq.psel && apbReq.penable;
    assign wrAccess    = accessPhase && apbReq.pwrite;
    assign addrHit     = (apbReq.paddr == OFFS_CRYSTAL) || (apbReq.paddr == OFFS_PLL)
                         || (apbReq.paddr == OFFS_FINALDIV);
    assign pready      = accessPhase;
    assign prdata      = prdata_q;
    assign pslverr     = pslverr_q && accessPhase;

    // two-flop synchronisers for all analog and foreign-clock inputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= {pllLockRaw, crystalReadyRaw, pllClk, crystalClk, ringOscClk};
            syncB_q <= syncA_q;
        end
    end

    // ready only counts while the driver is on
    assign readyFlag = syncB_q[LANE_RDY] && xtalEn_q;
    // lock is passed straight from its synchroniser, ungated; it may fall while running, nothing latches it
    assign lockFlag  = syncB_q[LANE_LOCK];

    // crystal enable register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            xtalEn_q <= XTAL_EN_RST;
        end else if (wrAccess && apbReq.paddr == OFFS_CRYSTAL) begin
            xtalEn_q <= apbReq.pwdata[XTAL_EN_BIT];
        end
    end

    // pll config register; a zero output divide code keeps the old code
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_q.refDiv     <= REFDIV_RST;
            cfg_q.vcoMul     <= MUL_RST;
            cfg_q.outDiv     <= OUTDIV_RST;
            cfg_q.pllSelect  <= PLLSEL_RST;
            cfg_q.refSelXtal <= REFSEL_RST;
            cfg_q.bypass     <= BYPASS_RST;
        end else if (wrAccess && apbReq.paddr == OFFS_PLL) begin
            cfg_q.refDiv     <= apbReq.pwdata[REFDIV_LSB +: REFDIV_W];
            cfg_q.vcoMul     <= apbReq.pwdata[MUL_LSB +: MUL_W];
            if (apbReq.pwdata[OUTDIV_LSB +: OUTDIV_W] != OUTDIV_BAD) begin
                cfg_q.outDiv <= apbReq.pwdata[OUTDIV_LSB +: OUTDIV_W];
            end
            cfg_q.pllSelect  <= apbReq.pwdata[PLLSEL_BIT];
            cfg_q.refSelXtal <= apbReq.pwdata[REFSEL_BIT];
            cfg_q.bypass     <= apbReq.pwdata[BYPASS_BIT];
        end
    end

    // final divider register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fdiv_q <= FDIV_RST;
            fone_q <= FONE_RST;
        end else if (wrAccess && apbReq.paddr == OFFS_FINALDIV) begin
            fdiv_q <= apbReq.pwdata[FDIV_LSB +: FDIV_W];
            fone_q <= apbReq.pwdata[FONE_LSB +: FONE_W];
        end
    end

    // read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'h0;
        end else if (setupPhase) begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= !addrHit;
            unique case (apbReq.paddr)
                OFFS_CRYSTAL: begin
                    prdata_q[XTAL_EN_BIT]  <= xtalEn_q;
                    prdata_q[XTAL_RDY_BIT] <= readyFlag;
                end
                OFFS_PLL: begin
                    prdata_q[REFDIV_LSB +: REFDIV_W] <= cfg_q.refDiv;
                    prdata_q[MUL_LSB +: MUL_W]       <= cfg_q.vcoMul;
                    prdata_q[OUTDIV_LSB +: OUTDIV_W] <= cfg_q.outDiv;
                    prdata_q[PLLSEL_BIT]             <= cfg_q.pllSelect;
                    prdata_q[REFSEL_BIT]             <= cfg_q.refSelXtal;
                    prdata_q[BYPASS_BIT]             <= cfg_q.bypass;
                    prdata_q[LOCK_BIT]               <= lockFlag;
                end
                OFFS_FINALDIV: begin
                    prdata_q[FDIV_LSB +: FDIV_W] <= fdiv_q;
                    prdata_q[FONE_LSB +: FONE_W] <= fone_q;
                end
                default: begin
                    prdata_q <= 32'h00000000;
                end
            endcase
        end
    end

    // controls toward the oscillator pad and the analog pll
    assign crystalEnable = xtalEn_q;
    assign pllPowerDown  = cfg_q.bypass;
    assign pllCfg        = cfg_q;

    // reference mux and bypass; clocks are sampled, so the path tracks at ref_clk rate
    assign pllRef  = cfg_q.refSelXtal ? syncB_q[LANE_XTAL] : syncB_q[LANE_RING];
    assign pllPath = cfg_q.bypass ? pllRef : syncB_q[LANE_PLL];
    assign pathRise = pllPath && !pathPrev_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pathPrev_q <= 1'h0;
        end else begin
            pathPrev_q <= pllPath;
        end
    end

    // final divider; new ratio taken only at a falling boundary to avoid runts
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q       <= 6'h00;
            divOut_q    <= 1'h0;
            activeN_q   <= FDIV_RST;
            activeOne_q <= 1'h1;
        end else if (activeOne_q) begin
            cnt_q    <= 6'h00;
            divOut_q <= 1'h0;
            if (!pllPath) begin
                activeN_q   <= fdiv_q;
                activeOne_q <= (fone_q != 6'h00);
            end
        end else if (pathRise) begin
            if (cnt_q == activeN_q) begin
                cnt_q    <= 6'h00;
                divOut_q <= !divOut_q;
                if (divOut_q) begin
                    activeN_q   <= fdiv_q;
                    activeOne_q <= (fone_q != 6'h00);
                end
            end else begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end

    assign finalClk = activeOne_q ? pllPath : divOut_q;

    // main clock select moves only while both candidates are low
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            selActive_q <= PLLSEL_RST;
            hfClk_q     <= 1'h0;
        end else begin
            if (!finalClk && !syncB_q[LANE_RING]) begin
                selActive_q <= cfg_q.pllSelect;
            end
            hfClk_q <= selActive_q ? finalClk : syncB_q[LANE_RING];
        end
    end

    assign hfClk = hfClk_q;

    // every check here runs on the register clock and sleeps through reset;
    // the reset-value checks at the bottom override that to watch the release
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // an apb setup cycle aimed at one register
    sequence readSetup(logic [11:0] addr);
        setupPhase && apbReq.paddr == addr;
    endsequence

    // the access cycle of a pll config write
    sequence pllWrite;
        wrAccess && apbReq.paddr == OFFS_PLL;
    endsequence

    // the access cycle of a final divider write
    sequence divWrite;
        wrAccess && apbReq.paddr == OFFS_FINALDIV;
    endsequence

    // clock path: crystal pass-through, ring fallback, pll route
    // the mux output is registered, so each check on hfClk_q looks one cycle back
    chk_xtal_pass_thru: assert property (
        (cfg_q.bypass && cfg_q.refSelXtal && selActive_q && activeOne_q)[*2]
        |-> hfClk_q == $past(syncB_q[LANE_XTAL]))
        else $error("crystal not passed through in bypass");
    chk_ring_select: assert property (
        !selActive_q |=> hfClk_q == $past(syncB_q[LANE_RING]))
        else $error("ring clock not selected");
    chk_pll_drive: assert property (
        selActive_q |=> hfClk_q == $past(finalClk))
        else $error("pll path not driving the main clock");
    chk_bypass_ref: assert property (
        cfg_q.bypass |-> pllPath == pllRef)
        else $error("bypassed path does not follow the reference");

    // register writes and the refused output divide code
    chk_xtal_en_write: assert property (
        wrAccess && apbReq.paddr == OFFS_CRYSTAL
        |=> xtalEn_q == $past(apbReq.pwdata[XTAL_EN_BIT]))
        else $error("crystal enable write lost");
    chk_refdiv_write: assert property (
        pllWrite |=> cfg_q.refDiv == $past(apbReq.pwdata[REFDIV_LSB +: REFDIV_W]))
        else $error("reference divide write lost");
    chk_mul_write: assert property (
        pllWrite |=> cfg_q.vcoMul == $past(apbReq.pwdata[MUL_LSB +: MUL_W]))
        else $error("vco multiply write lost");
    chk_outdiv_zero: assert property (
        pllWrite ##0 (apbReq.pwdata[OUTDIV_LSB +: OUTDIV_W] == OUTDIV_BAD)
        |=> $stable(cfg_q.outDiv))
        else $error("output divide zero code accepted");
    chk_bypass_power: assert property (
        pllWrite ##0 apbReq.pwdata[BYPASS_BIT] |=> pllPowerDown ##0 cfg_q.bypass)
        else $error("bypass write did not power down");
    chk_pll_wake: assert property (
        pllWrite ##0 !apbReq.pwdata[BYPASS_BIT] |=> !pllPowerDown)
        else $error("pll left powered down after bypass cleared");
    chk_fdiv_write: assert property (
        divWrite |=> fdiv_q == $past(apbReq.pwdata[FDIV_LSB +: FDIV_W])
            && fone_q == $past(apbReq.pwdata[FONE_LSB +: FONE_W]))
        else $error("final divider write lost");

    // status readback; read data is captured in the setup cycle
    // a fixed two-flop latency keeps the flags free of metastable reads
    chk_ready_readback: assert property (
        readSetup(OFFS_CRYSTAL)
        |=> prdata[XTAL_RDY_BIT] == $past(syncB_q[LANE_RDY] && xtalEn_q))
        else $error("crystal ready readback wrong");
    chk_lock_readback: assert property (
        readSetup(OFFS_PLL) |=> prdata[LOCK_BIT] == $past(syncB_q[LANE_LOCK]))
        else $error("lock readback wrong");
    chk_lock_fall: assert property (
        readSetup(OFFS_PLL) ##0 !syncB_q[LANE_LOCK] |=> !prdata[LOCK_BIT])
        else $error("dropped lock still reads as locked");
    chk_lock_sync: assert property (
        $past(rst_n, 3) |-> syncB_q[LANE_LOCK] == $past(pllLockRaw, 2))
        else $error("lock synchroniser latency wrong");
    chk_ready_sync: assert property (
        $past(rst_n, 3) |-> syncB_q[LANE_RDY] == $past(crystalReadyRaw, 2))
        else $error("ready synchroniser latency wrong");

    // divider counting and glitch-free switching
    chk_div_hold: assert property (
        !activeOne_q && !pathRise |=> $stable(divOut_q))
        else $error("divider output moved without an input edge");
    chk_div_count: assert property (
        !activeOne_q && pathRise && cnt_q != activeN_q
        |=> cnt_q == $past(cnt_q) + 6'h01 && $stable(divOut_q))
        else $error("divider count did not advance");
    chk_switch_low: assert property (
        $changed(selActive_q) |-> $past(!finalClk && !syncB_q[LANE_RING]))
        else $error("clock select moved while a source was high");
    chk_div_start: assert property (
        $fell(activeOne_q) |-> !divOut_q)
        else $error("divider left pass-through with its output high");

    // reset values, watched across the release itself; the default
    // disable would otherwise hide exactly the cycle these care about
    chk_pll_reset: assert property (
        disable iff (1'b0) !rst_n |=> cfg_q.refDiv == REFDIV_RST && cfg_q.vcoMul == MUL_RST
            && cfg_q.outDiv == OUTDIV_RST && cfg_q.pllSelect == PLLSEL_RST
            && cfg_q.refSelXtal == REFSEL_RST && cfg_q.bypass == BYPASS_RST)
        else $error("pll config reset value wrong");
    chk_xtal_reset: assert property (
        disable iff (1'b0) !rst_n |=> xtalEn_q == XTAL_EN_RST)
        else $error("crystal enable reset value wrong");
    chk_fdiv_reset: assert property (
        disable iff (1'b0) !rst_n
        |=> fdiv_q == FDIV_RST && fone_q == FONE_RST && activeOne_q)
        else $error("final divider reset value wrong");
endmodule : crystal_pll_clock_control

/* inc/clock_ctrl_pkg.sv */
// shared constants and carriers for the crystal and pll clock control block
package clock_ctrl_pkg;
    // register byte offsets inside the power and clock control space
    localparam logic [11:0] OFFS_CRYSTAL  = 12'h004;
    localparam logic [11:0] OFFS_PLL      = 12'h008;
    localparam logic [11:0] OFFS_FINALDIV = 12'h00C;

    // crystal oscillator config fields
    localparam int XTAL_EN_BIT  = 30;
    localparam int XTAL_RDY_BIT = 31;
    localparam logic XTAL_EN_RST = 1'h1;

    // pll config fields
    localparam int REFDIV_LSB   = 0;
    localparam int REFDIV_W     = 3;
    localparam int MUL_LSB      = 4;
    localparam int MUL_W        = 6;
    localparam int OUTDIV_LSB   = 10;
    localparam int OUTDIV_W     = 2;
    localparam int PLLSEL_BIT   = 16;
    localparam int REFSEL_BIT   = 17;
    localparam int BYPASS_BIT   = 18;
    localparam int LOCK_BIT     = 31;
    localparam logic [2:0] REFDIV_RST = 3'h1;
    localparam logic [5:0] MUL_RST    = 6'h1F;
    localparam logic [1:0] OUTDIV_RST = 2'h3;
    localparam logic [1:0] OUTDIV_BAD = 2'h0;
    localparam logic PLLSEL_RST = 1'h0;
    localparam logic REFSEL_RST = 1'h1;
    localparam logic BYPASS_RST = 1'h1;

    // final divider fields
    localparam int FDIV_LSB    = 0;
    localparam int FDIV_W      = 6;
    localparam int FONE_LSB    = 8;
    localparam int FONE_W      = 6;
    localparam logic [5:0] FDIV_RST = 6'h00;
    localparam logic [5:0] FONE_RST = 6'h01;

    // synchroniser lanes
    localparam int SYNC_N    = 5;
    localparam int LANE_RING = 0;
    localparam int LANE_XTAL = 1;
    localparam int LANE_PLL  = 2;
    localparam int LANE_RDY  = 3;
    localparam int LANE_LOCK = 4;

    // apb request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apbReq_type;

    // pll settings handed to the analog macro
    typedef struct packed {
        logic [2:0] refDiv;
        logic [5:0] vcoMul;
        logic [1:0] outDiv;
        logic       pllSelect;
        logic       refSelXtal;
        logic       bypass;
    } pllCfg_type;
endpackage : clock_ctrl_pkg

/* dv/crystal_source.sv */
// behavioural crystal source on the far side of the oscillator pads
`timescale 1ns/10ps
module crystal_source #(
    parameter int HALF_CYC  = 4,
    parameter int START_CYC = 20
) (
    input  wire logic ref_clk,
    input  wire logic crystalEnable,
    output logic      crystalClk = 1'b0,
    output logic      crystalReadyRaw = 1'b0
);
    int phase = 0;
    int age   = 0;

    // oscillation and ready only with the driver on; slow start-up models settling
    always @(posedge ref_clk) begin
        if (crystalEnable !== 1'b1) begin
            phase           <= 0;
            age             <= 0;
            crystalClk      <= 1'b0;
            crystalReadyRaw <= 1'b0;
        end else begin
            phase <= (phase == HALF_CYC - 1) ? 0 : phase + 1;
            if (phase == HALF_CYC - 1) crystalClk <= ~crystalClk;
            if (age < START_CYC) age <= age + 1;
            crystalReadyRaw <= (age >= START_CYC);
        end
    end
endmodule : crystal_source

/* dv/tb.sv */
// self-checking bench for the crystal and pll clock control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin nFail++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb
    import clock_ctrl_pkg::*;
;
    typedef struct packed { logic err; logic [31:0] data; logic [31:0] mask; } note_type;
    localparam int SETTLE_CYC = 20000; // 100 us of 5 ns cycles before lock is trusted
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    apbReq_type  apbReq = '0;
    logic        ringOscClk = 1'b0;
    logic        pllClk = 1'b0;
    logic        pllLockRaw = 1'b0;
    logic [31:0] prdata, v, w;
    logic        pready, pslverr, crystalClk, crystalReadyRaw, crystalEnable, pllPowerDown;
    logic        hfClk, prevHf;
    pllCfg_type  pllCfg;
    note_type    notes[$];
    note_type    got;
    int          nFail = 0, nChecks = 0, cycles = 0, ringCnt = 0, pllCnt = 0, edges;
    int          ev[6] = '{40, 30, 40, 24, 6, 12};
    logic [31:0] pv[6] = '{32'h60DF1, 32'h70DF1, 32'h50DF1, 32'h10DF1, 32'h10DF1, 32'h10DF1};
    logic [31:0] fv[6] = '{32'h100, 32'h100, 32'h100, 32'h100, 32'h001, 32'h000};

    crystal_pll_clock_control u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .apbReq(apbReq),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ringOscClk(ringOscClk),
        .crystalClk(crystalClk), .pllClk(pllClk), .crystalReadyRaw(crystalReadyRaw),
        .pllLockRaw(pllLockRaw), .crystalEnable(crystalEnable),
        .pllPowerDown(pllPowerDown), .pllCfg(pllCfg), .hfClk(hfClk));
    crystal_source u_xtal (.ref_clk(ref_clk), .crystalEnable(crystalEnable),
        .crystalClk(crystalClk), .crystalReadyRaw(crystalReadyRaw));

    always #2.5 ref_clk = ~ref_clk;

    // ring and pll stand-ins; a powered-down pll gives no clock
    always @(posedge ref_clk) begin
        ringCnt <= (ringCnt == 2) ? 0 : ringCnt + 1;
        if (ringCnt == 2) ringOscClk <= ~ringOscClk;
        pllCnt <= (pllCnt == 4) ? 0 : pllCnt + 1;
        if (pllCnt == 4) pllClk <= pllPowerDown ? 1'b0 : ~pllClk;
    end

    // hang guard, well above the lock settle wait plus the few thousand other cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            nFail++;
            conclude();
        end
    end

    // oldest note is matched against each completed apb access
    always @(posedge ref_clk) begin
        if (rst_n && apbReq.psel && apbReq.penable && pready === 1'b1) begin
            got = notes.pop_front();
            `CHK("pslverr", got.err, pslverr)
            `CHK("prdata", got.data, prdata & got.mask)
        end
    end

    // one apb transfer; a read notes the expected word under its mask
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                       input logic [31:0] m, input logic e);
        notes.push_back('{e, wr ? 32'h0 : d, wr ? 32'h0 : m});
        apbReq <= '{1'b1, 1'b0, wr, ad, wr ? d : 32'h0};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        // wait for the answer; only the hang guard ends a stuck transfer
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        apbReq <= '0;
        @(posedge ref_clk);
    endtask : apb

    task automatic conclude();
        $display("checks %0d mismatches %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    initial begin
        void'($urandom(32'h681B0682));
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (40) @(posedge ref_clk);
        apb(0, OFFS_CRYSTAL, 32'hC0000000, '1, 0);
        apb(0, OFFS_PLL, 32'h00060DF1, '1, 0);
        apb(0, OFFS_FINALDIV, 32'h00000100, '1, 0);
        `CHK("pllCfg", pllCfg_type'({3'h1, 6'h1F, 2'h3, 3'b011}), pllCfg)
        `CHK("pllPowerDown", 1'b1, pllPowerDown)
        $display("reset values done");
        // unmapped places refuse and leave state alone
        apb(1, {10'($urandom_range(1023, 4)), 2'b00}, $urandom, 0, 1);
        apb(0, 12'h000, 32'h0, '1, 1);
        apb(0, OFFS_PLL, 32'h00060DF1, '1, 0);
        for (int i = 1; i < 4; i++) begin
            w = $urandom;
            v = {13'h0, 3'b110, 4'h0, 2'(i), w[9:4], 1'b0, w[2:0]};
            apb(1, OFFS_PLL, v | (w & 32'hFFF8F008), 0, 0);
            apb(0, OFFS_PLL, v, '1, 0);
        end
        apb(1, OFFS_PLL, v & ~32'hC00, 0, 0);
        apb(0, OFFS_PLL, v, '1, 0);
        `CHK("pllCfg", pllCfg_type'({v[2:0], v[9:4], v[11:10], 3'b011}), pllCfg)
        $display("pll fields done");
        apb(1, OFFS_CRYSTAL, 32'h0, 0, 0);
        `CHK("crystalEnable", 1'b0, crystalEnable)
        repeat (10) @(posedge ref_clk);
        apb(0, OFFS_CRYSTAL, 32'h0, '1, 0);
        apb(1, OFFS_CRYSTAL, 32'h40000000, 0, 0);
        apb(0, OFFS_CRYSTAL, 32'h40000000, '1, 0);
        repeat (40) @(posedge ref_clk);
        apb(0, OFFS_CRYSTAL, 32'hC0000000, '1, 0);
        // lock is seen only after the synchroniser delay
        pllLockRaw <= 1'b1;
        apb(0, OFFS_PLL, 32'h0, 32'h80000000, 0);
        apb(0, OFFS_PLL, 32'h80000000, 32'h80000000, 0);
        pllLockRaw <= 1'b0;
        repeat (4) @(posedge ref_clk);
        apb(0, OFFS_PLL, 32'h0, 32'h80000000, 0);
        $display("flags done");
        for (int i = 0; i < 6; i++) begin
            apb(1, OFFS_PLL, pv[i], 0, 0);
            apb(1, OFFS_FINALDIV, fv[i], 0, 0);
            `CHK("pllPowerDown", pv[i][BYPASS_BIT], pllPowerDown)
            repeat (100) @(posedge ref_clk);
            edges = 0;
            prevHf = hfClk;
            repeat (240) begin
                @(posedge ref_clk);
                if (hfClk === 1'b1 && prevHf === 1'b0) edges++;
                prevHf = hfClk;
            end
            `CHK("hfClk edges", 1'b1, 1'(edges >= ev[i] - 2 && edges <= ev[i] + 2))
        end
        $display("clock path done");
        // the pll now runs; lock is read only after its settling time
        pllLockRaw <= 1'b1;
        repeat (SETTLE_CYC) @(posedge ref_clk);
        apb(0, OFFS_PLL, 32'h80000000, 32'h80000000, 0);
        $display("lock settle done");
        conclude();
    end
endmodule : tb
